// File: design/touch_adc_consts.svh
`ifndef TOUCH_ADC_CONSTS_SVH
`define TOUCH_ADC_CONSTS_SVH
// Fixed upper five bits of the slave address.
`define ADDR_PREFIX 5'h12
// Upper five bits of a high-speed master code.
`define HS_MASTER_CODE 5'h01
// Function code of the setup command.
`define FN_SETUP 4'hb
// Setup bits after power-on reset.
`define SETUP_RST 4'h0
// Byte returned once the master acknowledges the second result byte.
`define FILL_BYTE 8'hff
// Bit count of a whole byte and of the function nibble.
`define BYTE_BITS 4'h8
`define NIBBLE_BITS 4'h4
// Pin reset levels: both bus lines high, select pins low.
`define PIN_RST 4'h3
`endif

// File: design/touch_adc_pkg.sv
`default_nettype none
package touch_adc_pkg;
  // Command byte as it arrives, most significant field first.
  typedef struct packed {
    logic [3:0] function_select_nibble;  // Converter function.
    logic [1:0] power_state_field;       // Power state after the cycle.
    logic       res_8bit;                // Set for 8-bit conversion.
    logic       spare;                   // Ignored bit.
  } cmd_s;
  // Touch screen driver enables.
  typedef struct packed {
    logic xp;  // X+ driver.
    logic xn;  // X- driver.
    logic yp;  // Y+ driver.
    logic yn;  // Y- driver.
  } drivers_s;
  // Link side protocol states.
  // Nine states need four bits of code.
  typedef enum logic [3:0] {
    LS_IDLE, LS_ADDR, LS_ADDR_ACK, LS_HOLD, LS_CMD, LS_CMD_ACK, LS_TX, LS_TX_ACK, LS_REFUSE
  } link_state_e;
endpackage : touch_adc_pkg
`default_nettype wire

// File: design/touch_adc_i2c_command_port.sv
// Functional notes
// - Answer only prefix 10010 plus select pins.
// - Read select pins at each address byte.
// - Address bit zero: one reads, zero writes.
// - Acknowledge a matching address byte.
// - Power field sets converter and pen interrupt.
// - Apply power state after conversion completes.
// - Bit one picks 12-bit or 8-bit.
// - Upper nibble picks input, function, drivers.
// - Nibble 1011 is setup; power bits zero.
// - Setup bits: filter bypass, large pull-up.
// - Setup bits change only by setup, reset.
// - Acknowledge one command byte, master then ends.
// - Further command bytes are not acknowledged.
// - Channel picked early; drivers on at acquisition.
// - Acquire from nibble end to stop, convert.
// - Mux off in conversion; drivers stay on.
// - Read sends result bits eleven to four.
// - Second byte sends bits three to zero.
// - Acknowledged second byte yields all ones after.
// - Never acknowledge master code; enter high speed.
// - In high speed, stretch SCL until ready.
`include "touch_adc_consts.svh"
`default_nettype none
module touch_adc_i2c_command_port (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire logic               link_clk,
  input  wire logic               scl_i,
  output logic                    scl_o,
  output logic                    scl_oe,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe,
  input  wire logic [1:0]         addr_select_pins,
  output logic [3:0]              adc_channel,
  output touch_adc_pkg::drivers_s drv,
  output logic                    mux_connect,
  output logic                    conv_start,
  output logic                    conv_8bit,
  input  wire logic               conv_done,
  input  wire logic [11:0]        conv_result,
  output logic                    adc_power_on,
  output logic                    pen_irq_enable,
  output logic                    filter_bypass,
  output logic                    pullup_large
);
  // Reserved function codes sit in the single-ended half.
  function automatic logic is_reserved(input logic [3:0] fn);
    is_reserved = !fn[3] && (fn != 4'h0) && (fn != 4'h2) && (fn != 4'h4);
  endfunction : is_reserved

  // Codes that start an acquisition and a conversion.
  function automatic logic is_measure(input logic [3:0] fn);
    is_measure = !is_reserved(fn) && (fn != `FN_SETUP);
  endfunction : is_measure

  // Driver pattern for each function code.
  function automatic touch_adc_pkg::drivers_s drivers_of(input logic [3:0] fn);
    case (fn)
      4'h8, 4'hc: drivers_of = 4'hc;
      4'h9, 4'hd: drivers_of = 4'h3;
      4'ha, 4'he, 4'hf: drivers_of = 4'h6;
      default: drivers_of = 4'h0;
    endcase
  endfunction : drivers_of

  // Read byte by position: high result, low result, then filler.
  function automatic logic [7:0] tx_load(input logic [1:0] n, input logic [11:0] r);
    case (n)
      2'h0: tx_load = r[11:4];
      2'h1: tx_load = {r[3:0], 4'h0};
      default: tx_load = `FILL_BYTE;
    endcase
  endfunction : tx_load

  // Event seen once stages two and three agree on a new toggle level.
  function automatic logic sync_event(input logic [2:0] s, input logic f);
    sync_event = (s[1] == s[2]) && (s[2] != f);
  endfunction : sync_event

  logic [3:0]                  pin_s1, pin_s2, pin_s3, pin_f, pin_q;  // Pin synchroniser.
  touch_adc_pkg::link_state_e  state;             // Protocol state.
  logic [3:0]                  bit_cnt;           // Bits of the current byte.
  logic [7:0]                  shift;             // Received byte.
  logic [7:0]                  tx_byte;           // Bits still to send.
  logic [1:0]                  byte_no;           // Read bytes finished, saturating.
  logic                        rw;                // Direction of this transfer.
  logic                        hs_mode;           // High-speed mode armed.
  logic                        acq_pending;       // Acquisition running.
  logic                        acq_tgl, conv_tgl; // Events toward the core clock.
  logic [3:0]                  acq_fn;            // Function of this acquisition.
  touch_adc_pkg::cmd_s         cmd_held;          // Last accepted command.
  logic [3:0]                  setup_config_bits; // Static setup bits.
  logic [2:0]                  rtg_s;             // Result toggle synchroniser.
  logic                        rtg_f;             // Accepted result toggle level.
  logic [11:0]                 res_word;          // Result on the link side.
  logic                        res_ready;         // Result present for reading.
  logic [2:0]                  atg_s, ctg_s;      // Core side synchronisers.
  logic                        atg_f, ctg_f;      // Accepted core side levels.
  logic                        conv_busy;         // Conversion in progress.
  logic [1:0]                  pwr;               // Power field of this conversion.
  logic [11:0]                 result;            // Result on the core side.
  logic                        res_tgl;           // Result event toward the link.
  logic                        scl_f, sda_f, scl_rise, scl_fall, start_c, stop_c;
  logic [1:0]                  asel_f;
  logic                        conv_fire, setup_wr, acq_ev, conv_ev;
  logic [7:0]                  load_byte;

  // Both lines are open drain and only ever pulled low.
  assign scl_o = 1'b0;
  assign sda_o = 1'b0;
  assign filter_bypass = setup_config_bits[1];
  assign pullup_large = setup_config_bits[0];

  // Filtered pins and bus conditions; a glitch shorter than one link cycle is dropped.
  assign scl_f = pin_f[0];
  assign sda_f = pin_f[1];
  assign asel_f = pin_f[3:2];
  assign scl_rise = scl_f && !pin_q[0];
  assign scl_fall = !scl_f && pin_q[0];
  assign start_c = scl_f && pin_q[0] && pin_q[1] && !sda_f;
  assign stop_c = scl_f && pin_q[0] && !pin_q[1] && sda_f;
  assign conv_fire = acq_pending && (start_c || stop_c);
  assign setup_wr = (state == touch_adc_pkg::LS_CMD) && scl_fall && (bit_cnt == `BYTE_BITS)
                    && (shift[7:4] == `FN_SETUP) && !start_c && !stop_c;
  assign load_byte = tx_load(byte_no, res_word);

  // Pins pass three stages; the first stage feeds only the second.
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      pin_s1 <= `PIN_RST;
      pin_s2 <= `PIN_RST;
      pin_s3 <= `PIN_RST;
      pin_f <= `PIN_RST;
      pin_q <= `PIN_RST;
    end else begin
      pin_s1 <= {addr_select_pins, sda_i, scl_i};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      for (int i = 0; i < 4; i++) begin
        if (pin_s2[i] == pin_s3[i]) begin
          pin_f[i] <= pin_s3[i];
        end
      end
      pin_q <= pin_f;
    end
  end

  // Results cross by toggle; the word is stable until the next conversion ends.
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      rtg_s <= 3'h0;
      rtg_f <= 1'b0;
      res_word <= 12'h000;
      res_ready <= 1'b0;
    end else begin
      rtg_s <= {rtg_s[1:0], res_tgl};
      if (sync_event(rtg_s, rtg_f)) begin
        rtg_f <= rtg_s[2];
        res_word <= result;
        res_ready <= 1'b1;
      end else if (conv_fire) begin
        res_ready <= 1'b0;
      end
    end
  end

  // Protocol engine: bytes in, acknowledges, read bytes out.
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      state <= touch_adc_pkg::LS_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      tx_byte <= 8'h00;
      byte_no <= 2'h0;
      rw <= 1'b0;
      hs_mode <= 1'b0;
      sda_oe <= 1'b0;
      scl_oe <= 1'b0;
      acq_pending <= 1'b0;
      acq_tgl <= 1'b0;
      conv_tgl <= 1'b0;
      acq_fn <= 4'h0;
      cmd_held <= '0;
    end else begin
      // Stop or repeated start closes acquisition and starts conversion.
      if (conv_fire) begin
        conv_tgl <= ~conv_tgl;
        acq_pending <= 1'b0;
      end
      if (start_c || stop_c) begin
        state <= start_c ? touch_adc_pkg::LS_ADDR : touch_adc_pkg::LS_IDLE;
        hs_mode <= hs_mode && !stop_c;
        bit_cnt <= 4'h0;
        byte_no <= 2'h0;
        sda_oe <= 1'b0;
        scl_oe <= 1'b0;
      end else begin
        case (state)
          touch_adc_pkg::LS_ADDR, touch_adc_pkg::LS_CMD: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_f};
              bit_cnt <= bit_cnt + 4'h1;
            end
            // The fall after the last function bit opens acquisition.
            if (scl_fall && (state == touch_adc_pkg::LS_CMD) && (bit_cnt == `NIBBLE_BITS)
                && is_measure(shift[3:0])) begin
              acq_tgl <= ~acq_tgl;
              acq_fn <= shift[3:0];
              acq_pending <= 1'b1;
            end
            if (scl_fall && (bit_cnt == `BYTE_BITS)) begin
              bit_cnt <= 4'h0;
              if (state == touch_adc_pkg::LS_ADDR) begin
                if (shift[7:1] == {`ADDR_PREFIX, asel_f}) begin
                  sda_oe <= 1'b1;
                  rw <= shift[0];
                  state <= touch_adc_pkg::LS_ADDR_ACK;
                end else begin
                  // A master code is never acknowledged; it only arms high speed.
                  hs_mode <= hs_mode || (shift[7:3] == `HS_MASTER_CODE);
                  state <= touch_adc_pkg::LS_REFUSE;
                end
              end else if (is_reserved(shift[7:4])) begin
                state <= touch_adc_pkg::LS_REFUSE;
              end else begin
                sda_oe <= 1'b1;
                cmd_held <= shift;
                state <= touch_adc_pkg::LS_CMD_ACK;
              end
            end
          end
          touch_adc_pkg::LS_ADDR_ACK, touch_adc_pkg::LS_HOLD: begin
            if ((state == touch_adc_pkg::LS_HOLD) || scl_fall) begin
              if (!rw) begin
                sda_oe <= 1'b0;
                state <= touch_adc_pkg::LS_CMD;
              end else if (hs_mode && !res_ready) begin
                // Hold the clock low until a result sits in the shift path.
                sda_oe <= 1'b0;
                scl_oe <= 1'b1;
                state <= touch_adc_pkg::LS_HOLD;
              end else begin
                // The clock is let go one cycle later so the bit has set up.
                sda_oe <= ~load_byte[7];
                tx_byte <= {load_byte[6:0], 1'b0};
                bit_cnt <= 4'h1;
                state <= touch_adc_pkg::LS_TX;
              end
            end
          end
          touch_adc_pkg::LS_CMD_ACK: begin
            if (scl_fall) begin
              sda_oe <= 1'b0;
              state <= touch_adc_pkg::LS_REFUSE;
            end
          end
          touch_adc_pkg::LS_TX: begin
            scl_oe <= 1'b0;
            if (scl_fall) begin
              if (bit_cnt == `BYTE_BITS) begin
                sda_oe <= 1'b0;
                byte_no <= (byte_no == 2'h2) ? byte_no : byte_no + 2'h1;
                state <= touch_adc_pkg::LS_TX_ACK;
              end else begin
                sda_oe <= ~tx_byte[7];
                tx_byte <= {tx_byte[6:0], 1'b0};
                bit_cnt <= bit_cnt + 4'h1;
              end
            end
          end
          touch_adc_pkg::LS_TX_ACK: begin
            if (scl_rise && sda_f) begin
              state <= touch_adc_pkg::LS_REFUSE;
            end else if (scl_fall) begin
              sda_oe <= ~load_byte[7];
              tx_byte <= {load_byte[6:0], 1'b0};
              bit_cnt <= 4'h1;
              state <= touch_adc_pkg::LS_TX;
            end
          end
          touch_adc_pkg::LS_IDLE, touch_adc_pkg::LS_REFUSE: begin
            sda_oe <= 1'b0;
          end
          default: begin
            state <= touch_adc_pkg::LS_IDLE;
          end
        endcase
      end
    end
  end

  // Setup bits survive every other command.
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      setup_config_bits <= `SETUP_RST;
    end else if (setup_wr) begin
      setup_config_bits <= shift[3:0];
    end
  end

  // The channel follows the function bits as soon as the nibble is in.
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      adc_channel <= 4'h0;
    end else if ((state == touch_adc_pkg::LS_CMD) && scl_rise && (bit_cnt == 4'h3)
                 && is_measure({shift[2:0], sda_f}) && !start_c && !stop_c) begin
      adc_channel <= {shift[2:0], sda_f};
    end
  end

  // Link events into the core clock.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      atg_s <= 3'h0;
      ctg_s <= 3'h0;
      atg_f <= 1'b0;
      ctg_f <= 1'b0;
    end else begin
      atg_s <= {atg_s[1:0], acq_tgl};
      ctg_s <= {ctg_s[1:0], conv_tgl};
      if (acq_ev) begin
        atg_f <= atg_s[2];
      end
      if (conv_ev) begin
        ctg_f <= ctg_s[2];
      end
    end
  end
  assign acq_ev = sync_event(atg_s, atg_f);
  assign conv_ev = sync_event(ctg_s, ctg_f);

  // Acquisition, conversion and the power state that follows it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      drv <= '0;
      mux_connect <= 1'b0;
      conv_start <= 1'b0;
      conv_8bit <= 1'b0;
      conv_busy <= 1'b0;
      pwr <= 2'h0;
      adc_power_on <= 1'b0;
      pen_irq_enable <= 1'b1;
      result <= 12'h000;
      res_tgl <= 1'b0;
    end else begin
      conv_start <= 1'b0;
      if (acq_ev) begin
        drv <= drivers_of(acq_fn);
        mux_connect <= 1'b1;
      end
      if (conv_ev) begin
        // Drivers stay as they are through the conversion.
        mux_connect <= 1'b0;
        conv_start <= 1'b1;
        conv_busy <= 1'b1;
        conv_8bit <= cmd_held.res_8bit;
        pwr <= cmd_held.power_state_field;
      end else if (conv_busy && conv_done) begin
        conv_busy <= 1'b0;
        result <= conv_result;
        res_tgl <= ~res_tgl;
        adc_power_on <= pwr[0];
        pen_irq_enable <= ~pwr[0];
        if (!pwr[0]) begin
          drv <= '0;
        end
      end
    end
  end

  sequence s_addr_hit;
    (state == touch_adc_pkg::LS_ADDR) && scl_fall && !start_c && !stop_c && (bit_cnt == `BYTE_BITS);
  endsequence
  sequence s_acq_end;
    acq_pending && (start_c || stop_c);
  endsequence

  chk_addr_ack_drive: assert property (@(posedge link_clk) disable iff (!nrst)
    s_addr_hit ##0 (shift[7:1] == {`ADDR_PREFIX, asel_f}) |=> sda_oe ##1 sda_oe)
    else $error("matching address not acknowledged");
  chk_addr_miss_quiet: assert property (@(posedge link_clk) disable iff (!nrst)
    s_addr_hit ##0 (shift[7:3] != `ADDR_PREFIX) |=> !sda_oe && (state == touch_adc_pkg::LS_REFUSE))
    else $error("foreign address acknowledged");
  chk_dir_select: assert property (@(posedge link_clk) disable iff (!nrst)
    (state == touch_adc_pkg::LS_ADDR_ACK) && scl_fall && !start_c && !stop_c && !rw
    |=> state == touch_adc_pkg::LS_CMD)
    else $error("write direction not followed");
  chk_reserved_nack: assert property (@(posedge link_clk) disable iff (!nrst)
    (state == touch_adc_pkg::LS_CMD) && scl_fall && !start_c && !stop_c && (bit_cnt == `BYTE_BITS)
    && is_reserved(shift[7:4]) |=> !sda_oe && !$changed(cmd_held))
    else $error("reserved command acknowledged");
  chk_refuse_quiet: assert property (@(posedge link_clk) disable iff (!nrst)
    state == touch_adc_pkg::LS_REFUSE |-> !sda_oe)
    else $error("data line driven while refusing");
  chk_setup_static: assert property (@(posedge link_clk) disable iff (!nrst)
    !setup_wr |=> $stable(setup_config_bits))
    else $error("setup bits changed without setup");
  chk_conv_after_acq: assert property (@(posedge link_clk) disable iff (!nrst)
    s_acq_end |=> (conv_tgl != $past(conv_tgl)) && !acq_pending)
    else $error("conversion did not follow acquisition");
  chk_second_byte: assert property (@(posedge link_clk) disable iff (!nrst)
    (state == touch_adc_pkg::LS_TX_ACK) && scl_fall && !start_c && !stop_c && (byte_no == 2'h1)
    |=> sda_oe == !$past(res_word[3]))
    else $error("second byte does not start with bit three");
  chk_fill_ones: assert property (@(posedge link_clk) disable iff (!nrst)
    (state == touch_adc_pkg::LS_TX) && (byte_no == 2'h2) |-> !sda_oe)
    else $error("filler byte not all ones");
  chk_power_late: assert property (@(posedge clk) disable iff (!nrst)
    conv_busy && !conv_done |=> $stable(adc_power_on) && $stable(pen_irq_enable))
    else $error("power state changed during conversion");
  chk_mux_released: assert property (@(posedge clk) disable iff (!nrst)
    conv_ev |=> !mux_connect && conv_start ##1 !conv_start)
    else $error("mux not released at conversion start");
endmodule : touch_adc_i2c_command_port
`default_nettype wire

// File: verif/host_master.sv
`default_nettype none
// Host bus master, bit-banged; both lines are open drain with pull-ups.
module host_master (
  input  wire logic clk,
  input  wire logic scl,
  input  wire logic sda,
  output logic      scl_m,
  output logic      sda_m,
  output logic      hung
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    scl_m = 1'b1;
    sda_m = 1'b1;
    hung  = 1'b0;
  end
  // A quarter bit; every change lands one step after a clk edge.
  task automatic tick();
    repeat (40) @(posedge clk);
    #1;
  endtask : tick
  // Releases SCL, then waits (bounded) while the device stretches it.
  task automatic rise();
    int k;
    scl_m = 1'b1;
    for (k = 0; k < 20000 && scl !== 1'b1; k++) @(posedge clk);
    if (k == 20000) hung = 1'b1;
  endtask : rise
  // START, or repeated START when SCL is low.
  task automatic start();
    sda_m = 1'b1;
    tick();
    rise();
    tick();
    sda_m = 1'b0;
    tick();
    scl_m = 1'b0;
    tick();
  endtask : start
  // STOP ends a transfer.
  task automatic stop();
    sda_m = 1'b0;
    tick();
    rise();
    tick();
    sda_m = 1'b1;
    tick();
  endtask : stop
  // One bit: data set while SCL low, wire sampled mid high phase.
  task automatic bit_io(input logic b, output logic r);
    sda_m = b;
    tick();
    rise();
    tick();
    r = sda;
    tick();
    scl_m = 1'b0;
    tick();
  endtask : bit_io
  // Sends a byte and returns the acknowledge seen.
  task automatic put(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], r);
    bit_io(1'b1, r);
    ack = ~r;
  endtask : put
  // Reads a byte, then acknowledges it or not.
  task automatic get(input logic mack, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(~mack, r);
  endtask : get
endmodule : host_master
`default_nettype wire

// File: verif/touch_adc_i2c_command_port_tb_top.sv
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin errors++; $display("Error t=%0t got %h exp %h", $time, a, b); end end
module touch_adc_i2c_command_port_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, link_clk, nrst, scl, sda, scl_m, sda_m, hung, scl_o, scl_oe, sda_o, sda_oe;
  logic        mux_connect, conv_start, conv_8bit, conv_done, adc_power_on, pen_irq_enable;
  logic        filter_bypass, pullup_large, pw, ac, m_seen;
  logic [1:0]  sel;
  logic [3:0]  adc_channel, setup;
  logic [7:0]  b;
  logic [11:0] conv_result, last;
  logic [7:0]  exp_q[$];
  int          errors, n_compared, starts, stretch_cyc;
  touch_adc_pkg::drivers_s drv;
  // Wired-AND of the open-drain lines; released lines read high.
  assign scl = scl_m & ~(scl_oe & ~scl_o);
  assign sda = sda_m & ~(sda_oe & ~sda_o);
  touch_adc_i2c_command_port u_touch_adc_i2c_command_port (
    .clk(clk), .nrst(nrst), .link_clk(link_clk), .scl_i(scl), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .addr_select_pins(sel), .adc_channel(adc_channel),
    .drv(drv), .mux_connect(mux_connect), .conv_start(conv_start), .conv_8bit(conv_8bit),
    .conv_done(conv_done), .conv_result(conv_result), .adc_power_on(adc_power_on),
    .pen_irq_enable(pen_irq_enable), .filter_bypass(filter_bypass), .pullup_large(pullup_large)
  );
  host_master u_host_master (.clk(clk), .scl(scl), .sda(sda), .scl_m(scl_m), .sda_m(sda_m), .hung(hung));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Link clock is offset so its edges never meet a core clock edge or a stimulus change one step later.
  initial begin
    link_clk = 1'b0;
    #5;
    forever #32 link_clk = ~link_clk;
  end
  // Counts conversion starts and records the mode given with each.
  always @(posedge clk) if (conv_start === 1'b1) begin
    starts++;
    m_seen = conv_8bit;
  end
  // Counts core cycles in which the device holds SCL low.
  always @(posedge clk) if (scl_oe === 1'b1) stretch_cyc++;
  // Driver pattern expected for a function code.
  function automatic logic [3:0] exp_drv(input logic [3:0] c);
    case (c)
      4'h8, 4'hc: return 4'hc;
      4'h9, 4'hd: return 4'h3;
      4'ha, 4'he, 4'hf: return 4'h6;
      default: return 4'h0;
    endcase
  endfunction : exp_drv
  task automatic wrap_up();
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  // Write address then command; ac holds the command acknowledge.
  task automatic wr(input logic [7:0] c);
    u_host_master.start();
    u_host_master.put({5'h12, sel, 1'b0}, ac);
    `CHK(ac, 1'b1)
    u_host_master.put(c, ac);
  endtask : wr
  // Plays the converter for one conversion and checks the power timing.
  task automatic convert(input logic [1:0] pd, input logic m, input logic [3:0] c, input int k0);
    int k;
    for (k = 0; k < 200 && starts == k0; k++) @(posedge clk);
    #1;
    `CHK(starts, k0 + 1)
    `CHK(m_seen, m)
    `CHK(mux_connect, 1'b0)
    `CHK(drv, exp_drv(c))
    repeat (20) @(posedge clk);
    #1;
    `CHK({adc_power_on, pen_irq_enable}, {pw, ~pw})
    last = 12'($urandom);
    conv_result = last;
    conv_done = 1'b1;
    @(posedge clk);
    #1;
    conv_done = 1'b0;
    pw = pd[0];
    repeat (4) @(posedge clk);
    #1;
    `CHK({adc_power_on, pen_irq_enable}, {pw, ~pw})
    `CHK(drv, pw ? exp_drv(c) : 4'h0)
  endtask : convert
  initial begin
    repeat (100000) @(posedge clk);
    errors++;
    wrap_up();
  end
  initial begin
    logic [3:0] c;
    logic [1:0] pd;
    logic       m, rsv;
    int         k;
    void'($urandom(32'hd680));
    nrst = 1'b0;
    conv_done = 1'b0;
    conv_result = 12'h000;
    sel = 2'($urandom);
    pw = 1'b0;
    setup = 4'h0;
    repeat (2) @(posedge link_clk);
    @(posedge clk);
    #1;
    nrst = 1'b1;
    `CHK({filter_bypass, pullup_large, adc_power_on, pen_irq_enable, drv}, 8'h10)
    repeat (6) @(posedge link_clk);
    @(posedge clk);
    #1;
    u_host_master.start();
    u_host_master.put({5'h12, ~sel, 1'b0}, ac);
    `CHK(ac, 1'b0)
    u_host_master.stop();
    // Every function code once; power field steps through all four values.
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      pd = i[1:0];
      m = 1'($urandom);
      b = 8'($urandom);
      rsv = c inside {4'h1, 4'h3, 4'h5, 4'h6, 4'h7};
      k = starts;
      wr((c == 4'hb) ? {c, 2'b00, b[1:0]} : {c, pd, m, b[7]});
      `CHK(ac, ~rsv)
      if (!rsv && c != 4'hb) begin
        `CHK(adc_channel, c)
        `CHK(drv, exp_drv(c))
        `CHK(mux_connect, 1'b1)
      end
      if (i == 0) begin
        u_host_master.put(8'h00, ac);
        `CHK(ac, 1'b0)
      end
      u_host_master.stop();
      if (c == 4'hb) setup = {2'b00, b[1:0]};
      if (rsv || c == 4'hb) begin
        repeat (60) @(posedge clk);
        `CHK(starts, k)
      end else begin
        convert(pd, m, c, k);
      end
      `CHK({filter_bypass, pullup_large}, setup[1:0])
    end
    // New select pins, then a high-speed read of the last result.
    sel = 2'($urandom);
    repeat (2500) @(posedge clk);
    #1;
    exp_q = '{last[11:4], {last[3:0], 4'h0}, 8'hff};
    u_host_master.start();
    u_host_master.put({5'h01, 3'($urandom)}, ac);
    `CHK(ac, 1'b0)
    u_host_master.start();
    u_host_master.put({5'h12, sel, 1'b1}, ac);
    `CHK(ac, 1'b1)
    for (int j = 0; j < 3; j++) begin
      u_host_master.get(j != 2, b);
      `CHK(b, exp_q.pop_front())
    end
    u_host_master.stop();
    `CHK(hung, 1'b0)
    // A high-speed read before the result is ready: the device must hold SCL low until it is.
    k = starts;
    wr({4'hc, 2'b01, 2'b00});
    `CHK(ac, 1'b1)
    u_host_master.stop();
    last = 12'($urandom);
    exp_q = '{last[11:4], {last[3:0], 4'h0}, 8'hff};
    fork
      begin
        u_host_master.start();
        u_host_master.put({5'h01, 3'($urandom)}, ac);
        `CHK(ac, 1'b0)
        u_host_master.start();
        u_host_master.put({5'h12, sel, 1'b1}, ac);
        `CHK(ac, 1'b1)
        for (int j = 0; j < 3; j++) begin
          u_host_master.get(j != 2, b);
          `CHK(b, exp_q.pop_front())
        end
        u_host_master.stop();
      end
      begin
        // The converter answers late, well after the read address has been taken.
        repeat (4000) @(posedge clk);
        #1;
        conv_result = last;
        conv_done = 1'b1;
        @(posedge clk);
        #1;
        conv_done = 1'b0;
      end
    join
    `CHK(starts, k + 1)
    `CHK({adc_power_on, pen_irq_enable}, 2'b10)
    `CHK({hung, stretch_cyc > 0}, 2'b01)
    wrap_up();
  end
endmodule : touch_adc_i2c_command_port_tb_top
`default_nettype wire
